/* design/gledp_port.sv */
// Five configurable pins and eight LED dies with PWM, sampled inputs
// and edge capture. Assumes a synchronous command port on mclk and
// that pin inputs are already synchronous to mclk.
//
// Notes on behaviour
// R1: Inputs sampled at steady 50 Hz
// R2: Rise and fall seen since last query kept
// R3: Levels debounced before reporting
// R4: 0 low, 100 high, 1-99 PWM duty
// R5: Pin index valid from 0 to 12
// R6: Indices 5-12 are LED dies, bottom up
// R7: Config byte ignored for LED indices
// R8: Drive codes 000, 001, 010 decoded
// R9: Drive codes 011, 100, 101, 111 decoded
// R10: Reserved drive code 110 answered with error
// R11: Function bit selects default role or user
// R12: Host writes zero to reserved config bits
// R13: Pins 1-3 default to host power roles
// R14: Write sets state, optionally configuration too
// R15: Query returns index, state, PWM, configuration
// R16: Index above 12 rejected, nothing changed
// R17: Query clears that pin's edge record
// R18: Control pins high-impedance except during pulse
`timescale 1ns/10ps
module gledp_port #(
  parameter int STEP_CYC = gledp_pkg::STEP_CYC,
  parameter int SAMP_CYC = gledp_pkg::SAMP_CYC
) (
  input  wire logic                         mclk,
  input  wire logic                         sys_rst,
  input  wire logic [4:0]                   addr,
  input  wire logic [31:0]                  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [31:0]                  rdata,
  input  wire logic [gledp_pkg::NGPIO-1:0]  gpio_in,
  output logic      [gledp_pkg::NGPIO-1:0]  gpio_out,
  output logic      [gledp_pkg::NGPIO-1:0]  gpio_oe_n,
  output logic      [gledp_pkg::NGPIO-1:0]  gpio_pu,
  output logic      [gledp_pkg::NGPIO-1:0]  gpio_pd,
  output logic      [gledp_pkg::NLED-1:0]   led_output_channel,
  input  wire logic                         pwr_pulse,
  input  wire logic                         pwr_level,
  input  wire logic                         rst_pulse,
  input  wire logic                         rst_level,
  output logic                              host_power_sense,
  output logic                              irq
);
  import gledp_pkg::*;

  localparam int PRE_W  = $clog2(STEP_CYC + 1);
  localparam int SAMP_W = $clog2(SAMP_CYC + 1);

  generate
    if (STEP_CYC < 1 || SAMP_CYC < 2) begin : g_bad
      $error("gledp_port: timing counts too small");
    end
  endgenerate

  typedef struct packed {
    logic [NPIN-1:0][6:0]  st;
    logic [NGPIO-1:0][3:0] cfg;
    logic [NPIN-1:0]       pwm;
    logic [PRE_W-1:0]      pre;
    logic [6:0]            pct;
    logic [SAMP_W-1:0]     samp_cnt;
    logic [NGPIO-1:0]      samp;
    logic [NGPIO-1:0]      level;
    logic [NGPIO-1:0]      rise;
    logic [NGPIO-1:0]      fall;
    logic [1:0]            qedge;
    logic [31:0]           reply;
    logic [1:0]            istat;
    logic [1:0]            ien;
    logic [31:0]           rdata;
    logic [NGPIO-1:0]      gout;
    logic [NGPIO-1:0]      oe_n;
    logic [NGPIO-1:0]      pu;
    logic [NGPIO-1:0]      pd;
    logic                  sense;
    logic                  irq;
  } gledp_state_t;

  gledp_state_t q;
  gledp_state_t n;

  logic       samp_tick;
  logic       pre_tick;
  logic [7:0] widx;
  logic [7:0] qidx;
  logic [3:0] wcfg;
  logic       wr_ok;
  logic       wr_err;
  logic       qry_ok;

  assign samp_tick = q.samp_cnt == SAMP_W'(SAMP_CYC - 1);
  assign pre_tick  = q.pre == PRE_W'(STEP_CYC - 1);
  assign widx      = wdata[WR_IDX_LSB +: 8];
  assign qidx      = wdata[WR_IDX_LSB +: 8];
  assign wcfg      = wdata[WR_CFG_LSB +: 4];
  // Reserved drive code only refused when a config byte is carried
  assign wr_err = wr && addr == A_WRITE && (widx > MAX_IDX              // R16
    || (wdata[WR_CFGV] && widx < LED_BASE && wcfg[2:0] == DM_RSVD));    // R10
  assign wr_ok  = wr && addr == A_WRITE && !wr_err;
  assign qry_ok = wr && addr == A_QUERY && qidx <= MAX_IDX;             // R5

  // Pin drive as {out, oe_n, pull-up, pull-down} for a mode and level
  function automatic logic [3:0] drive(input logic [2:0] m, input logic l);
    logic [3:0] d;
    d = 4'h4;
    unique case (m)
      DM_PD:      d = l ? 4'h8 : 4'h5;                                  // R8
      DM_PP_FAST: d = {l, 3'h0};                                        // R8
      DM_HIZ:     d = 4'h4;                                             // R8
      DM_PU:      d = l ? 4'h6 : 4'h0;                                  // R9
      DM_HI_ONLY: d = l ? 4'h8 : 4'h4;                                  // R9
      DM_PP:      d = {l, 3'h0};                                        // R9
      DM_RSVD:    d = 4'h4;
      DM_LO_ONLY: d = l ? 4'h4 : 4'h0;                                  // R9
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.rdata = 32'h0000_0000;

    // PWM time base: 100 percent steps per 10 ms period
    n.pre = pre_tick ? '0 : q.pre + PRE_W'(1);
    if (pre_tick) begin
      n.pct = (q.pct == PCT_LAST) ? 7'h00 : q.pct + 7'h01;
    end
    for (int i = 0; i < NPIN; i++) begin
      n.pwm[i] = q.st[i] > q.pct;                                       // R4
    end

    // Query: capture reply, then drop that pin's edge record
    if (qry_ok) begin
      n.reply = {4'h0, (qidx < LED_BASE) ? q.cfg[qidx[2:0]] : 4'h0,
                 7'h00, q.pwm[qidx[3:0]], 1'b0, q.st[qidx[3:0]],
                 qidx};                                                 // R15
      n.qedge = 2'h0;
      if (qidx < LED_BASE) begin
        n.qedge = {q.rise[qidx[2:0]], q.fall[qidx[2:0]]};               // R2
        n.rise[qidx[2:0]] = 1'b0;                                       // R17
        n.fall[qidx[2:0]] = 1'b0;                                       // R17
      end
    end

    // Interrupt clear comes before every event below, so a same-cycle
    // event still lands
    if (wr && addr == A_ICLR) begin
      n.istat = q.istat & ~wdata[1:0];
    end

    // Sampling at a fixed rate; a new level needs two equal samples,
    // so chatter shorter than one period never reaches the host
    n.samp_cnt = samp_tick ? '0 : q.samp_cnt + SAMP_W'(1);
    if (samp_tick) begin                                                // R1
      n.samp = gpio_in;
      for (int i = 0; i < NGPIO; i++) begin
        if (gpio_in[i] == q.samp[i] && gpio_in[i] != q.level[i]) begin
          n.level[i] = gpio_in[i];                                      // R3
          if (gpio_in[i]) begin
            n.rise[i] = 1'b1;                                           // R2
          end else begin
            n.fall[i] = 1'b1;                                           // R2
          end
          n.istat[IRQ_EDGE] = 1'b1;
        end
      end
    end

    // Write command: state always, config only for pins 0-4
    if (wr_ok) begin                                                    // R14
      n.st[widx[3:0]] = wdata[WR_ST_LSB +: 7];
      if (wdata[WR_CFGV] && widx < LED_BASE) begin                      // R7
        n.cfg[widx[2:0]] = wcfg;
      end
    end

    // Error flags and interrupt enable
    if (wr_err || (wr && addr == A_QUERY && !qry_ok)) begin             // R16
      n.istat[IRQ_ERR] = 1'b1;
    end
    if (wr && addr == A_IEN) begin
      n.ien = wdata[1:0];
    end
    n.irq = |(n.istat & n.ien);

    if (rd) begin
      unique case (addr)
        A_REPLY: n.rdata = q.reply;
        A_INPUT: n.rdata = {22'h0, q.qedge, 3'h0, q.level};
        A_ISTAT: n.rdata = {30'h0, q.istat};
        A_IEN:   n.rdata = {30'h0, q.ien};
        default: n.rdata = 32'h0000_0000;
      endcase
    end

    // Pin drivers: user mode follows PWM, default role otherwise
    n.sense = q.level[PIN_SENSE];                                       // R13
    for (int i = 0; i < NGPIO; i++) begin
      if (q.cfg[i][F_BIT]) begin                                        // R11
        {n.gout[i], n.oe_n[i], n.pu[i], n.pd[i]} =
          drive(q.cfg[i][2:0], q.pwm[i]);
      end else if (i == PIN_PWR) begin
        {n.gout[i], n.oe_n[i], n.pu[i], n.pd[i]} =
          {pwr_level, !pwr_pulse, 2'b00};                               // R18
      end else if (i == PIN_RST) begin
        {n.gout[i], n.oe_n[i], n.pu[i], n.pd[i]} =
          {rst_level, !rst_pulse, 2'b00};                               // R18
      end else begin
        {n.gout[i], n.oe_n[i], n.pu[i], n.pd[i]} = 4'h4;                // R11
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q      <= '0;
      q.cfg  <= {NGPIO{CFG_RESET}};
      q.oe_n <= '1;
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign rdata            = q.rdata;
  assign gpio_out         = q.gout;
  assign gpio_oe_n        = q.oe_n;
  assign gpio_pu          = q.pu;
  assign gpio_pd          = q.pd;
  assign led_output_channel = q.pwm[NPIN-1:NGPIO];                      // R6
  assign host_power_sense = q.sense;
  assign irq              = q.irq;

  ////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);

  pwm_low_a: assert property (q.st[5] == 7'h00 |=> !q.pwm[5]) // R4
    else $error("zero state not low");
  pwm_high_a: assert property (q.st[12] == 7'h64 [*2] |=> q.pwm[12]) // R4
    else $error("full state not high");
  bad_index_a: assert property (wr && addr == A_WRITE && widx > MAX_IDX
    |=> $stable(q.st) && $stable(q.cfg) && q.istat[IRQ_ERR]) // R16
    else $error("bad index changed settings");
  rsvd_mode_a: assert property (wr && addr == A_WRITE && wdata[WR_CFGV]
    && widx < LED_BASE && wcfg[2:0] == DM_RSVD
    |=> $stable(q.cfg) && q.istat[IRQ_ERR]) // R10
    else $error("reserved drive code accepted");
  led_cfg_a: assert property (wr && addr == A_WRITE && widx >= LED_BASE
    |=> $stable(q.cfg)) // R7
    else $error("LED index altered config");
  hiz_mode_a: assert property (q.cfg[0] == {1'b1, DM_HIZ}
    |=> q.oe_n[0] && !q.pu[0] && !q.pd[0]) // R8
    else $error("hi-z mode drives pin");
  pulse_idle_a: assert property (!q.cfg[PIN_PWR][F_BIT] && !pwr_pulse
    |=> q.oe_n[PIN_PWR]) // R18
    else $error("control pin driven without pulse");
  query_clr_a: assert property (qry_ok && qidx == 8'h00 && !samp_tick
    |=> !q.rise[0] && !q.fall[0]) // R17
    else $error("query left edge record");
  sample_rate_a: assert property ($changed(q.level) |-> $past(samp_tick)) // R1
    else $error("level moved off sample tick");
  reply_idx_a: assert property (qry_ok // R15
    |=> q.reply[7:0] == $past(qidx))
    else $error("reply index wrong");

  // Sampling, debounce and edge record
  sample_hold_a: assert property (!samp_tick |=> $stable(q.samp)) // R1
    else $error("sample taken off tick");
  edge_rise_a: assert property (samp_tick && gpio_in[4] && q.samp[4] // R2
    && !q.level[4] |=> q.rise[4] && q.level[4])
    else $error("rise not recorded");
  edge_fall_a: assert property (samp_tick && !gpio_in[4] && !q.samp[4] // R2
    && q.level[4] |=> q.fall[4] && !q.level[4])
    else $error("fall not recorded");
  edge_irq_a: assert property ($changed(q.level) |-> q.istat[IRQ_EDGE]) // R2
    else $error("edge flag lost");
  debounce_a: assert property (samp_tick && gpio_in[4] != q.samp[4] // R3
    |=> $stable(q.level[4]))
    else $error("single sample moved level");
  sense_a: assert property (1'b1 // R13
    |=> q.sense == $past(q.level[PIN_SENSE]))
    else $error("sense not following pin");

  // Commands, PWM and pin drive
  write_state_a: assert property (wr_ok // R14
    |=> q.st[$past(widx[3:0])] == $past(wdata[WR_ST_LSB +: 7]))
    else $error("write lost state");
  query_err_a: assert property (wr && addr == A_QUERY && qidx > MAX_IDX // R16
    |=> $stable(q.reply) && q.istat[IRQ_ERR])
    else $error("bad query accepted");
  pct_wrap_a: assert property (pre_tick && q.pct == PCT_LAST // R4
    |=> q.pct == 7'h00)
    else $error("duty counter past last step");
  pp_drive_a: assert property (q.cfg[0] == {1'b1, DM_PP} // R9
    |=> !q.oe_n[0] && q.gout[0] == $past(q.pwm[0]))
    else $error("push-pull not driven");
  pd_low_a: assert property (q.cfg[0] == {1'b1, DM_PD} && !q.pwm[0] // R8
    |=> q.oe_n[0] && q.pd[0] && !q.pu[0])
    else $error("pull-down mode wrong");
  default_hiz_a: assert property (!q.cfg[0][F_BIT] // R11
    |=> q.oe_n[0] && !q.pu[0] && !q.pd[0])
    else $error("default role pin driven");
  pwr_drive_a: assert property (!q.cfg[PIN_PWR][F_BIT] && pwr_pulse // R18
    |=> !q.oe_n[PIN_PWR] && q.gout[PIN_PWR] == $past(pwr_level))
    else $error("power pulse not driven");
  rst_drive_a: assert property (!q.cfg[PIN_RST][F_BIT] && rst_pulse // R18
    |=> !q.oe_n[PIN_RST] && q.gout[PIN_RST] == $past(rst_level))
    else $error("reset pulse not driven");
endmodule

/* design/gledp_pkg.sv */
// Constants for the pin and LED controller: register map, command
// fields, drive codes and timing. Assumes a 250 MHz system clock.
package gledp_pkg;
  localparam int CLK_HZ   = 250_000_000;
  localparam int PWM_HZ   = 100;
  localparam int SAMP_HZ  = 50;
  localparam int PCT_FULL = 100;
  // One PWM percent step, and one input sample period, in clock cycles
  localparam int STEP_CYC = CLK_HZ / (PWM_HZ * PCT_FULL);
  localparam int SAMP_CYC = CLK_HZ / SAMP_HZ;

  localparam int NPIN  = 13;
  localparam int NGPIO = 5;
  localparam int NLED  = 8;
  localparam logic [7:0] MAX_IDX  = 8'h0C;
  localparam logic [7:0] LED_BASE = 8'h05;
  localparam logic [6:0] PCT_LAST = 7'h63;

  // Register byte addresses
  localparam logic [4:0] A_WRITE = 5'h00;
  localparam logic [4:0] A_QUERY = 5'h04;
  localparam logic [4:0] A_REPLY = 5'h08;
  localparam logic [4:0] A_INPUT = 5'h0C;
  localparam logic [4:0] A_ISTAT = 5'h10;
  localparam logic [4:0] A_ICLR  = 5'h14;
  localparam logic [4:0] A_IEN   = 5'h18;

  // Write command word fields
  localparam int WR_IDX_LSB = 0;
  localparam int WR_ST_LSB  = 8;
  localparam int WR_CFG_LSB = 16;
  localparam int WR_CFGV    = 24;
  localparam int EDGE_LSB   = 8;

  // Configuration nibble: function bit over drive_mode_code
  localparam int F_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h2;

  localparam logic [2:0] DM_PD      = 3'h0;
  localparam logic [2:0] DM_PP_FAST = 3'h1;
  localparam logic [2:0] DM_HIZ     = 3'h2;
  localparam logic [2:0] DM_PU      = 3'h3;
  localparam logic [2:0] DM_HI_ONLY = 3'h4;
  localparam logic [2:0] DM_PP      = 3'h5;
  localparam logic [2:0] DM_RSVD    = 3'h6;
  localparam logic [2:0] DM_LO_ONLY = 3'h7;

  localparam int PIN_SENSE = 1;
  localparam int PIN_PWR   = 2;
  localparam int PIN_RST   = 3;

  localparam int IRQ_ERR  = 0;
  localparam int IRQ_EDGE = 1;
endpackage

/* dv/gledp_host.sv */
// Host model: register writes and reads in the bench's place.
// Assumes one mclk domain and a slave that never stalls.
`timescale 1ns/10ps
module gledp_host (
  input  wire logic        mclk,
  output logic      [4:0]  addr,
  output logic      [31:0] wdata,
  output logic             wr,
  output logic             rd,
  input  wire logic [31:0] rdata
);
  initial begin
    addr  = 5'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // Released lines get scrambled so stale data is never trusted
  task automatic put(input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask
  task automatic get(input logic [4:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    addr <= ~a;
    @(posedge mclk);
    d = rdata;
  endtask
endmodule

/* dv/gledp_port_test.sv */
// Self-checking bench for the pin and LED controller.
// Assumes short STEP_CYC and SAMP_CYC so the run stays brief.
`timescale 1ns/10ps
module gledp_port_test;
  import gledp_pkg::*;
  localparam int STP = 2;
  localparam int SMP = 8;
  logic             mclk = 1'b0;
  logic             sys_rst = 1'b1;
  logic [4:0]       addr;
  logic [31:0]      wdata, rdata, d;
  logic             wr, rd, sense, irq;
  logic             pwr_pulse = 1'b0, pwr_level = 1'b0;
  logic             rst_pulse = 1'b0, rst_level = 1'b0;
  logic [NGPIO-1:0] gpio_in = '0, gpio_out, gpio_oe_n, gpio_pu, gpio_pd;
  logic [NLED-1:0]  leds;
  logic [6:0]       st [NPIN];
  logic [3:0]       cf [NPIN];
  logic [2:0]       e3;
  integer           seed = 32'hfb95224d;
  int               num_errors = 0, total_checks = 0, n, j;
  always #2 mclk = ~mclk;
  gledp_port #(.STEP_CYC(STP), .SAMP_CYC(SMP)) i_gledp_port (
    .mclk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .gpio_in, .gpio_out,
    .gpio_oe_n, .gpio_pu, .gpio_pd, .led_output_channel(leds), .pwr_pulse,
    .pwr_level, .rst_pulse, .rst_level, .host_power_sense(sense), .irq);
  gledp_host i_gledp_host (.mclk, .addr, .wdata, .wr, .rd, .rdata);
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bench copy of pin state; refused commands leave it alone
  task automatic wcmd(logic [7:0] i, logic [6:0] s, logic [3:0] c, logic v);
    bit ok;
    ok = i <= MAX_IDX && !(v && i < LED_BASE && c[2:0] == DM_RSVD);
    i_gledp_host.put(A_WRITE, {7'h00, v, 4'h0, c, 1'b0, s, i});
    if (ok) st[i] = s;
    if (ok && v && i < LED_BASE) cf[i] = c;
    repeat (4) @(posedge mclk);
  endtask
  task automatic query(logic [7:0] i);
    i_gledp_host.put(A_QUERY, {24'h0, i});
    i_gledp_host.get(A_REPLY, d);
    chk("reply", {4'h0, cf[i], 7'h0, st[i] == 7'd100, 1'b0, st[i], i},
        (st[i] == 7'h00 || st[i] == 7'd100) ? d : d & 32'hFFFE_FFFF);
  endtask
  function automatic logic [2:0] dexp(logic [2:0] c, logic h);
    case (c)
      DM_PD:      return h ? 3'b000 : 3'b101;
      DM_HIZ:     return 3'b100;
      DM_PU:      return h ? 3'b110 : 3'b000;
      DM_HI_ONLY: return h ? 3'b000 : 3'b100;
      DM_LO_ONLY: return h ? 3'b100 : 3'b000;
      default:    return 3'b000;
    endcase
  endfunction
  task automatic rin(logic [31:0] e);
    i_gledp_host.get(A_INPUT, d);
    chk("input", e, d & 32'h3FF);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    for (n = 0; n < NPIN; n++) begin
      st[n] = 7'h00;
      cf[n] = n < NGPIO ? CFG_RESET : 4'h0;
    end
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    for (n = 0; n < NPIN; n++) query(n);
    for (n = 0; n < 40; n++) begin
      j = $unsigned($random(seed)) % NPIN;
      wcmd(j, $unsigned($random(seed)) % 101, {1'b1, 3'($random(seed))},
           1'($random(seed)));
      query(j);
    end
    i_gledp_host.put(A_ICLR, 32'h3);
    i_gledp_host.put(A_IEN, 32'h1);
    wcmd(8'h0D, 7'h64, 4'h0, 1'b0);
    wcmd(8'hFF, 7'h64, 4'hA, 1'b1);
    wcmd(1, 7'd10, {1'b1, DM_RSVD}, 1'b1);
    i_gledp_host.put(A_QUERY, 32'h0000_0020);
    for (n = 0; n < NPIN; n++) query(n);
    i_gledp_host.get(A_ISTAT, d);
    chk("istat", 32'h1, d);
    chk("irq", 1'b1, irq);
    i_gledp_host.get(A_IEN, d);
    chk("ien", 32'h1, d);
    i_gledp_host.get(5'h1C, d);
    chk("unmapped", 32'h0, d);
    i_gledp_host.put(A_ICLR, 32'h1);
    @(posedge mclk);
    chk("irq", 1'b0, irq);
    // Masked error must stay quiet on the line
    i_gledp_host.put(A_IEN, 32'h0);
    wcmd(8'h0E, 7'h00, 4'h0, 1'b0);
    chk("irq", 1'b0, irq);
    for (n = 0; n < NLED; n++) wcmd(LED_BASE + n, 7'h00, 4'h0, 1'b0);
    for (n = 0; n < NLED; n++) begin
      wcmd(LED_BASE + n, 7'd100, 4'hF, 1'b1);
      chk("led", 8'h01 << n, leds);
      wcmd(LED_BASE + n, 7'h00, 4'h0, 1'b0);
    end
    wcmd(LED_BASE, 7'd50, 4'h0, 1'b0);
    j = 0;
    for (n = 0; n < 100 * STP; n++) begin
      @(posedge mclk);
      j += leds[0];
    end
    chk("duty", 50 * STP, j);
    for (n = 0; n < 16; n++) begin
      if (n[3:1] != DM_RSVD) begin
        wcmd(0, n[0] ? 7'd100 : 7'd0, {1'b1, n[3:1]}, 1'b1);
        e3 = dexp(n[3:1], n[0]);
        chk("drive", e3, {gpio_oe_n[0], gpio_pu[0], gpio_pd[0]});
        if (!e3[2]) chk("out", n[0], gpio_out[0]);
      end
    end
    wcmd(0, 7'd100, 4'h5, 1'b1);
    chk("deflt", 1'b1, gpio_oe_n[0]);
    wcmd(2, 7'd0, CFG_RESET, 1'b1);
    wcmd(3, 7'd0, CFG_RESET, 1'b1);
    chk("idle", 2'b11, gpio_oe_n[3:2]);
    pwr_pulse <= 1'b1;
    rst_pulse <= 1'b1;
    rst_level <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("pulse", 4'b0010, {gpio_oe_n[3:2], gpio_out[3:2]});
    pwr_pulse <= 1'b0;
    rst_pulse <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("idle", 2'b11, gpio_oe_n[3:2]);
    query(4);
    gpio_in[4] <= 1'b1;
    repeat (SMP - 4) @(posedge mclk);
    gpio_in[4] <= 1'b0;
    repeat (3 * SMP) @(posedge mclk);
    rin(32'h000);
    gpio_in <= 5'h12;
    repeat (3 * SMP + 4) @(posedge mclk);
    rin(32'h012);
    chk("sense", 1'b1, sense);
    i_gledp_host.get(A_ISTAT, d);
    chk("istat", 32'h2, d & 32'h2);
    query(4);
    rin(32'h212);
    query(4);
    rin(32'h012);
    gpio_in <= 5'h00;
    repeat (3 * SMP + 4) @(posedge mclk);
    query(4);
    rin(32'h100);
    report_and_stop();
  end
endmodule
